// ### core/spd_pkg.sv
// constants for the script parameter decoder: opcodes, parameter fields,
// result codes and state encodings. no surroundings assumed.
package spd_pkg;
  localparam logic [7:0] SPD_CMD_SCRIPT     = 8'h88;
  localparam logic [7:0] SPD_OP_SEARCH_STEP = 8'h05;
  localparam logic [7:0] SPD_OP_SPEED       = 8'h0D;
  localparam logic [7:0] SPD_OP_WRITE_BIT   = 8'h01;
  localparam logic [7:0] SPD_OP_WRITE_BYTE  = 8'h03;
  localparam logic [7:0] SPD_OP_RESET       = 8'h00;
  localparam logic [7:0] SPD_RESULT_FAIL    = 8'h22;
  localparam logic [7:0] SPD_RESULT_OK      = 8'hAA;
  localparam int SPD_BIT_SPEED_INV = 7;
  localparam int SPD_BIT_SPEED     = 3;
  localparam int SPD_BIT_BYPASS    = 1;
  localparam int SPD_BIT_VALUE     = 0;
  localparam logic SPD_SPEED_STD_RST = 1'b0;

  typedef enum logic [2:0] {
    SPD_IDLE   = 3'b000,
    SPD_LEN    = 3'b001,
    SPD_OPCODE = 3'b010,
    SPD_PARAM  = 3'b011,
    SPD_WAIT   = 3'b100,
    SPD_DONE   = 3'b101
  } spd_state_t;
endpackage : spd_pkg

// ### core/spd_param_check.sv
// checks a speed parameter byte: speed copy agreement and chosen speed.
// assumes a byte from the same clock domain; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module spd_param_check
  import spd_pkg::*;
(
  input  wire logic [7:0] paramByte,   // speed parameter byte
  output logic            speedSel,    // decoded speed bit
  output logic            bypass,      // presence bypass bit
  output logic            malformed    // speed copy is not the complement
);
  // speed copy must be the complement of the speed bit
  assign speedSel  = paramByte[SPD_BIT_SPEED];
  assign bypass    = paramByte[SPD_BIT_BYPASS];
  assign malformed = paramByte[SPD_BIT_SPEED_INV] == paramByte[SPD_BIT_SPEED];
endmodule : spd_param_check
`default_nettype wire

// ### core/spd_decoder.sv
// script parameter decoder: takes script bytes from the i2c slave and
// drives speed, slot requests and script abort. the slave, the slot
// engine and the bus live outside on the same clock.
`timescale 1ns/1ps
`default_nettype none
module spd_decoder
  import spd_pkg::*;
(
  input  wire logic       clk,          // 250 MHz clock
  input  wire logic       rst,          // async reset, active high
  input  wire logic       byteValid,    // one-cycle pulse, byte from i2c
  input  wire logic [7:0] byteData,     // received byte
  input  wire logic       frameStart,   // pulse, start plus write address
  input  wire logic       opDone,       // pulse, slot engine finished
  input  wire logic       presenceSeen, // level with opDone for resets
  output logic            speedOverdrive, // speed setting, 1 overdrive
  output logic            opStart,      // pulse, start a primitive
  output logic [7:0]      opCode,       // primitive being run
  output logic [7:0]      opParam,      // decoded parameter byte
  output logic            scriptActive, // script being parsed
  output logic            scriptDone,   // pulse, script ended
  output logic [7:0]      resultCode    // last result code
);
  spd_state_t state_reg;
  logic [7:0] remain_reg;
  logic       bypass_reg;
  logic       rpSpeed;
  logic       rpBypass;
  logic       rpBad;

  spd_param_check u_check (
    .paramByte (byteData),
    .speedSel  (rpSpeed),
    .bypass    (rpBypass),
    .malformed (rpBad)
  );

  // opcodes that carry one parameter byte
  function automatic logic hasParam(input logic [7:0] op);
    hasParam = (op == SPD_OP_SPEED) || (op == SPD_OP_SEARCH_STEP) ||
               (op == SPD_OP_WRITE_BIT) || (op == SPD_OP_WRITE_BYTE);
  endfunction : hasParam

  // count one byte off the script length, clamped at zero
  function automatic logic [7:0] decLen(input logic [7:0] n);
    decLen = (n == 8'h00) ? 8'h00 : n - 8'h01;
  endfunction : decLen

  // parser state; the frame start from the slave restarts parsing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg  <= SPD_IDLE;
      remain_reg <= 8'h00;
    end else if (frameStart) begin
      state_reg <= SPD_IDLE;
    end else begin
      unique case (state_reg)
        SPD_IDLE: begin
          if (byteValid && byteData == SPD_CMD_SCRIPT) begin
            state_reg <= SPD_LEN;
          end
        end
        SPD_LEN: begin
          if (byteValid) begin
            remain_reg <= byteData;
            state_reg  <= (byteData == 8'h00) ? SPD_IDLE : SPD_OPCODE;
          end
        end
        SPD_OPCODE: begin
          if (remain_reg == 8'h00) begin
            state_reg <= SPD_DONE;
          end else if (byteValid) begin
            remain_reg <= decLen(remain_reg);
            state_reg  <= hasParam(byteData) ? SPD_PARAM : SPD_WAIT;
          end
        end
        SPD_PARAM: begin
          if (byteValid) begin
            remain_reg <= decLen(remain_reg);
            if (opCode == SPD_OP_SPEED && rpBad) begin
              state_reg <= SPD_DONE;
            end else begin
              state_reg <= SPD_WAIT;
            end
          end
        end
        SPD_WAIT: begin
          if (opDone) begin
            if (opCode == SPD_OP_RESET && !presenceSeen && !bypass_reg) begin
              state_reg <= SPD_DONE;
            end else begin
              state_reg <= SPD_OPCODE;
            end
          end
        end
        SPD_DONE: state_reg <= SPD_IDLE;
        default:  state_reg <= SPD_IDLE;
      endcase
    end
  end

  // opcode and parameter capture
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      opCode  <= 8'h00;
      opParam <= 8'h00;
    end else if (byteValid && state_reg == SPD_OPCODE && remain_reg != 8'h00) begin
      opCode  <= byteData;
      opParam <= 8'h00;
    end else if (byteValid && state_reg == SPD_PARAM) begin
      unique case (opCode)
        SPD_OP_WRITE_BIT:   opParam <= {7'h00, byteData[SPD_BIT_VALUE]};
        SPD_OP_SEARCH_STEP: opParam <= {7'h00, byteData[SPD_BIT_VALUE]};
        default:            opParam <= byteData;
      endcase
    end
  end

  // speed setting and presence bypass from the speed parameter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      speedOverdrive <= SPD_SPEED_STD_RST;
      bypass_reg     <= 1'b0;
    end else if (byteValid && state_reg == SPD_PARAM &&
                 opCode == SPD_OP_SPEED && !rpBad) begin
      speedOverdrive <= rpSpeed;
      bypass_reg     <= rpBypass;
    end
  end

  // primitive launch, one pulse per primitive entering the wait
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      opStart <= 1'b0;
    end else begin
      opStart <= byteValid && !frameStart &&
                 ((state_reg == SPD_OPCODE && remain_reg != 8'h00 &&
                   !hasParam(byteData)) ||
                  (state_reg == SPD_PARAM &&
                   !(opCode == SPD_OP_SPEED && rpBad)));
    end
  end

  // result reporting; a halt reports the failure code
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scriptActive <= 1'b0;
      scriptDone   <= 1'b0;
      resultCode   <= 8'h00;
    end else begin
      scriptActive <= !frameStart && state_reg != SPD_IDLE &&
                      state_reg != SPD_DONE;
      scriptDone   <= !frameStart && state_reg == SPD_DONE;
      if (!frameStart && state_reg == SPD_OPCODE && remain_reg == 8'h00) begin
        resultCode <= SPD_RESULT_OK;
      end else if (!frameStart && ((state_reg == SPD_PARAM && byteValid &&
                   opCode == SPD_OP_SPEED && rpBad) ||
                  (state_reg == SPD_WAIT && opDone &&
                   opCode == SPD_OP_RESET && !presenceSeen && !bypass_reg))) begin
        resultCode <= SPD_RESULT_FAIL;
      end
    end
  end

  // a malformed speed byte must never reach the speed setting
  a_speed_guard: assert property (@(posedge clk) disable iff (rst)
    (byteValid && state_reg == SPD_PARAM && opCode == SPD_OP_SPEED && rpBad
     && !frameStart) |=> $stable(speedOverdrive) && state_reg == SPD_DONE)
    else $error("malformed speed byte accepted");
  a_speed_update: assert property (@(posedge clk) disable iff (rst)
    (byteValid && state_reg == SPD_PARAM && opCode == SPD_OP_SPEED && !rpBad
     && !frameStart) |=> speedOverdrive == $past(byteData[SPD_BIT_SPEED]))
    else $error("speed not taken from parameter");
  a_speed_hold: assert property (@(posedge clk) disable iff (rst)
    (state_reg != SPD_PARAM || opCode != SPD_OP_SPEED) |=>
    $stable(speedOverdrive))
    else $error("speed changed outside speed primitive");
  a_halt_code: assert property (@(posedge clk) disable iff (rst)
    (state_reg == SPD_WAIT && opDone && opCode == SPD_OP_RESET &&
     !presenceSeen && !bypass_reg && !frameStart) |=>
    resultCode == SPD_RESULT_FAIL ##1 scriptDone)
    else $error("missing presence did not halt");
  a_bypass_go: assert property (@(posedge clk) disable iff (rst)
    (state_reg == SPD_WAIT && opDone && opCode == SPD_OP_RESET &&
     bypass_reg && !frameStart) |=> state_reg == SPD_OPCODE)
    else $error("bypass did not continue");
  a_bit_param: assert property (@(posedge clk) disable iff (rst)
    (byteValid && state_reg == SPD_PARAM && opCode == SPD_OP_WRITE_BIT
     && !frameStart) |=> opParam == {7'h00, $past(byteData[0])} && opStart)
    else $error("write bit parameter wrong");
  a_byte_param: assert property (@(posedge clk) disable iff (rst)
    (byteValid && state_reg == SPD_PARAM && opCode == SPD_OP_WRITE_BYTE
     && !frameStart) |=> opParam == $past(byteData))
    else $error("write byte parameter wrong");
  a_step_param: assert property (@(posedge clk) disable iff (rst)
    (byteValid && state_reg == SPD_PARAM && opCode == SPD_OP_SEARCH_STEP
     && !frameStart) |=> opParam[0] == $past(byteData[0]) && opStart)
    else $error("search direction wrong");
  a_param_skip: assert property (@(posedge clk) disable iff (rst)
    (byteValid && state_reg == SPD_OPCODE && remain_reg != 8'h00 &&
     hasParam(byteData) && !frameStart) |=> state_reg == SPD_PARAM)
    else $error("parameter byte not expected");

  c_speed: cover property (@(posedge clk) disable iff (rst)
    $rose(speedOverdrive));
  c_halt: cover property (@(posedge clk) disable iff (rst)
    scriptDone && resultCode == SPD_RESULT_FAIL);
  c_ok: cover property (@(posedge clk) disable iff (rst)
    scriptDone && resultCode == SPD_RESULT_OK);
  c_step: cover property (@(posedge clk) disable iff (rst)
    opStart && opCode == SPD_OP_SEARCH_STEP);
endmodule : spd_decoder
`default_nettype wire

// ### verification/spd_host_model.sv
// host and slot engine model: sends script bytes, answers primitives.
// assumes the decoder on the same clock; the bench calls the tasks.
`timescale 1ns/1ps
`default_nettype none
module spd_host_model
  import spd_pkg::*;
(
  input  wire logic       clk,          // shared clock
  input  wire logic       opStart,      // primitive request from decoder
  output logic            byteValid,    // byte strobe
  output logic [7:0]      byteData,     // byte value
  output logic            frameStart,   // start plus write address
  output logic            opDone,       // slot engine finished
  output logic            presenceSeen  // presence result
);
  int   lat  = 2;    // slot engine latency in cycles, 0 answers at once
  logic pres = 1'b1; // presence reported for the next reset primitive
  // quiet lines at time zero
  initial begin
    byteValid    = 1'b0;
    byteData     = 8'h00;
    frameStart   = 1'b0;
    opDone       = 1'b0;
    presenceSeen = 1'b0;
  end
  task frame();
    @(posedge clk);
    frameStart <= 1'b1;
    @(posedge clk);
    frameStart <= 1'b0;
  endtask : frame
  // one byte; idle data is inverted so a stale value never looks valid
  task send(input logic [7:0] b);
    @(posedge clk);
    byteValid <= 1'b1;
    byteData  <= b;
    @(posedge clk);
    byteValid <= 1'b0;
    byteData  <= ~b;
  endtask : send
  // frame, command, length, opcode and, except for the reset opcode, parameter as one script
  task script(input logic [7:0] op, input logic [7:0] par);
    frame();
    send(SPD_CMD_SCRIPT);
    send((op == SPD_OP_RESET) ? 8'h01 : 8'h02);
    send(op);
    if (op != SPD_OP_RESET) send(par);
  endtask : script
  // slot engine: done pulse after lat cycles, presence level alongside
  always begin
    @(posedge clk);
    if (opStart === 1'b1) begin
      repeat (lat) @(posedge clk);
      opDone       <= 1'b1;
      presenceSeen <= pres;
      @(posedge clk);
      opDone       <= 1'b0;
      presenceSeen <= ~pres;
    end
  end
endmodule : spd_host_model
`default_nettype wire

// ### verification/spd_decoder_tb.sv
// self-checking bench for the decoder: table of scripts, then odd cases.
// assumes the host model drives every decoder input except clk and rst.
`timescale 1ns/1ps
`default_nettype none
module spd_decoder_tb
  import spd_pkg::*;
;
  typedef struct packed {
    logic [7:0] op;   // opcode sent
    logic [7:0] par;  // parameter sent, unused bits zero
    logic       pres; // presence answered
    logic       st;   // primitive start expected
    logic       spd;  // speed expected afterwards
    logic [7:0] res;  // result code expected
  } spd_row_t;
  // unused parameter bits kept zero in every row
  spd_row_t rows [13] = '{
    '{8'h0D, 8'h08, 1'b0, 1'b1, 1'b1, 8'hAA}, '{8'h03, 8'hA5, 1'b0, 1'b1, 1'b1, 8'hAA},
    '{8'h0D, 8'h88, 1'b0, 1'b0, 1'b1, 8'h22}, '{8'h0D, 8'h80, 1'b0, 1'b1, 1'b0, 8'hAA},
    '{8'h00, 8'h00, 1'b0, 1'b1, 1'b0, 8'h22}, '{8'h00, 8'h00, 1'b1, 1'b1, 1'b0, 8'hAA},
    '{8'h0D, 8'h82, 1'b0, 1'b1, 1'b0, 8'hAA}, '{8'h00, 8'h00, 1'b0, 1'b1, 1'b0, 8'hAA},
    '{8'h0D, 8'h00, 1'b0, 1'b0, 1'b0, 8'h22}, '{8'h01, 8'h01, 1'b0, 1'b1, 1'b0, 8'hAA},
    '{8'h05, 8'h01, 1'b0, 1'b1, 1'b0, 8'hAA}, '{8'h05, 8'h00, 1'b0, 1'b1, 1'b0, 8'hAA},
    '{8'h03, 8'h5A, 1'b0, 1'b1, 1'b0, 8'hAA}};
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       byteValid, frameStart, opDone, presenceSeen;
  logic [7:0] byteData, opCode, opParam, resultCode;
  logic       speedOverdrive, opStart, scriptActive, scriptDone;
  int         errors = 0;
  int         nTests = 0;
  int         k;
  // 250 MHz clock
  always #2 clk = ~clk;
  spd_decoder dut (.clk(clk), .rst(rst), .byteValid(byteValid),
    .byteData(byteData), .frameStart(frameStart), .opDone(opDone),
    .presenceSeen(presenceSeen), .speedOverdrive(speedOverdrive),
    .opStart(opStart), .opCode(opCode), .opParam(opParam),
    .scriptActive(scriptActive), .scriptDone(scriptDone),
    .resultCode(resultCode));
  spd_host_model host (.clk(clk), .opStart(opStart), .byteValid(byteValid),
    .byteData(byteData), .frameStart(frameStart), .opDone(opDone),
    .presenceSeen(presenceSeen));
  // compare and count
  task chk(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // counts, verdict, end of run
  task report_and_stop();
    $display("errors=%0d comparisons=%0d", errors, nTests);
    if (errors == 0 && nTests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  // one script; watch for the start pulse until the end pulse
  task run(input spd_row_t r);
    logic       sawSt;
    logic       act;
    logic [7:0] code, par;
    int         i;
    sawSt = 1'b0;
    act   = 1'b0;
    code  = 8'h00;
    par   = 8'h00;
    host.pres = r.pres;
    host.script(r.op, r.par);
    for (i = 0; i < 60; i++) begin
      #1;
      // the last byte was taken while parsing, so the script shows active
      if (i == 0) act = scriptActive;
      if (opStart === 1'b1) begin
        sawSt = 1'b1;
        code  = opCode;
        par   = opParam;
      end
      if (scriptDone === 1'b1) break;
      @(posedge clk);
    end
    chk({7'h00, act}, 8'h01);
    chk({7'h00, scriptDone}, 8'h01);
    chk({7'h00, sawSt}, {7'h00, r.st});
    if (r.st) chk(code, r.op);
    if (r.op inside {SPD_OP_WRITE_BIT, SPD_OP_WRITE_BYTE, SPD_OP_SEARCH_STEP})
      chk(par, r.par);
    chk({7'h00, speedOverdrive}, {7'h00, r.spd});
    chk(resultCode, r.res);
  endtask : run
  // watchdog far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    report_and_stop();
  end
  // reset, table, then restart, empty script and reset while idle
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({4'h0, speedOverdrive, scriptActive, opStart, scriptDone}, 8'h00);
    chk(resultCode, 8'h00);
    for (k = 0; k < 13; k++) begin
      host.lat = (k % 2) * 5;
      run(rows[k]);
    end
    host.send(8'h55);
    host.send(SPD_CMD_SCRIPT);
    host.send(8'h02);
    host.send(SPD_OP_SPEED);
    run('{8'h0D, 8'h08, 1'b0, 1'b1, 1'b1, 8'hAA});
    host.frame();
    host.send(SPD_CMD_SCRIPT);
    host.send(8'h00);
    host.send(SPD_OP_SPEED);
    host.send(8'h80);
    #1;
    chk({6'h00, scriptActive, speedOverdrive}, 8'h01);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({7'h00, speedOverdrive}, 8'h00);
    run(rows[0]);
    report_and_stop();
  end
endmodule : spd_decoder_tb
`default_nettype wire
